// ==== logic/modem_path_switch.sv ====
/*
 * Serial path switch, panel controls and indicator drive of the radio modem.
 * Assumes byte streams from the host, radio and telephone modules on clk,
 * host handshake and panel contacts arriving asynchronously from pins,
 * and software on an Avalon-MM slave port with waitrequest.
 */
// How it works
// - Terminal-ready and request-to-send both asserted route the host to the radio.
// - Terminal-ready asserted, request-to-send negated route the host to the telephone.
// - Terminal-ready negated joins radio and telephone, host isolated.
// - Panel switch off holds request-to-send inactive; on passes the host line.
// - The reset button holds both modules in reset.
// - Both buttons, reset released, config released a second later enters command mode.
// - Bar graph lights three, two, one or no LEDs by fade margin.
// - Fade margin is signal strength minus receiver sensitivity.
// - Power LED stays lit and blinks off on each radio transmission.
// - Yellow shows traffic to the host, green traffic from the host.
// - Carrier LED lights while the telephone reports line up and carrier.
`timescale 1ns/1ps
module modem_path_switch #(
   parameter int DEBOUNCE_CYCLES = path_switch_pkg::DEBOUNCE_CYCLES,
   parameter int CMD_HOLD_CYCLES = path_switch_pkg::CMD_HOLD_CYCLES,
   parameter int BLINK_CYCLES = path_switch_pkg::BLINK_CYCLES
) (
   // Clocking.
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // Avalon-MM slave.
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Host handshake pins and panel contacts.
   input wire logic host_dtr,
   input wire logic host_rts,
   input wire logic reset_button,
   input wire logic config_button,
   input wire logic rts_panel_switch,
   // Host byte streams.
   input wire logic host_in_valid,
   input wire logic [7:0] host_in_data,
   output logic host_in_ready,
   output logic host_out_valid,
   output logic [7:0] host_out_data,
   input wire logic host_out_ready,
   // Radio module.
   input wire logic radio_out_valid,
   input wire logic [7:0] radio_out_data,
   output logic radio_out_ready,
   output logic radio_in_valid,
   output logic [7:0] radio_in_data,
   input wire logic radio_in_ready,
   input wire logic radio_tx_active,
   output logic radio_rst,
   output logic cmd_mode_entry,
   // Telephone module.
   input wire logic phone_out_valid,
   input wire logic [7:0] phone_out_data,
   output logic phone_out_ready,
   output logic phone_in_valid,
   output logic [7:0] phone_in_data,
   input wire logic phone_in_ready,
   input wire logic phone_line_up,
   input wire logic phone_dcd,
   output logic phone_rst,
   output logic rts_to_modules,
   // Indicators.
   output logic led_power,
   output logic led_serial_out,
   output logic led_serial_in,
   output logic [2:0] led_signal,
   output logic led_carrier
);
   typedef enum logic [1:0] {
      CMD_IDLE = 2'h0,
      CMD_BOTH = 2'h1,
      CMD_HOLD = 2'h2
   } cmd_state_t;

   // ************************************************************
   // Pin synchronisers and debounced panel contacts.
   // ************************************************************
   logic dtr_a, dtr_s, rts_a, rts_s;
   logic reset_db, config_db, panel_db;
   logic dtr_on, rts_on;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dtr_a <= 1'b0;
         dtr_s <= 1'b0;
         rts_a <= 1'b0;
         rts_s <= 1'b0;
      end else if (ce) begin
         dtr_a <= host_dtr;
         dtr_s <= dtr_a;
         rts_a <= host_rts;
         rts_s <= rts_a;
      end
   end

   input_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_reset_db (.clk(clk), .sys_rst(sys_rst), .ce(ce),
      .raw(reset_button), .clean(reset_db));
   input_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_config_db (.clk(clk), .sys_rst(sys_rst), .ce(ce),
      .raw(config_button), .clean(config_db));
   input_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_panel_db (.clk(clk), .sys_rst(sys_rst), .ce(ce),
      .raw(rts_panel_switch), .clean(panel_db));

   assign dtr_on = dtr_s;
   assign rts_on = panel_db && rts_s;

   // ************************************************************
   // Route selection.
   // ************************************************************
   path_switch_pkg::route_t route;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         route <= path_switch_pkg::ROUTE_CROSS;
         rts_to_modules <= 1'b0;
      end else if (ce) begin
         rts_to_modules <= rts_on;
         if (!dtr_on) begin
            route <= path_switch_pkg::ROUTE_CROSS;
         end else if (rts_on) begin
            route <= path_switch_pkg::ROUTE_RADIO;
         end else begin
            route <= path_switch_pkg::ROUTE_PHONE;
         end
      end
   end

   chk_route_radio: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && dtr_on && rts_on) |=> (route == path_switch_pkg::ROUTE_RADIO))
      else $error("host not routed to radio");
   chk_route_phone: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && dtr_on && !rts_on) |=> (route == path_switch_pkg::ROUTE_PHONE))
      else $error("host not routed to telephone");
   chk_rts_panel: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && !panel_db) |=> !rts_to_modules)
      else $error("request-to-send passed with panel switch off");

   // ************************************************************
   // Stream switching through two-entry buffers.
   // ************************************************************
   logic rbuf_valid, rbuf_ready, pbuf_valid, pbuf_ready, hbuf_valid, hbuf_ready;
   logic [7:0] rbuf_data, pbuf_data, hbuf_data;
   logic to_radio, to_phone, crossed;

   assign to_radio = (route == path_switch_pkg::ROUTE_RADIO);
   assign to_phone = (route == path_switch_pkg::ROUTE_PHONE);
   assign crossed = (route == path_switch_pkg::ROUTE_CROSS);

   always_comb begin
      rbuf_valid = (to_radio && host_in_valid) || (crossed && phone_out_valid);
      rbuf_data = to_radio ? host_in_data : phone_out_data;
      pbuf_valid = (to_phone && host_in_valid) || (crossed && radio_out_valid);
      pbuf_data = to_phone ? host_in_data : radio_out_data;
      hbuf_valid = (to_radio && radio_out_valid) || (to_phone && phone_out_valid);
      hbuf_data = to_radio ? radio_out_data : phone_out_data;
      host_in_ready = (to_radio && rbuf_ready) || (to_phone && pbuf_ready);
      radio_out_ready = (to_radio && hbuf_ready) || (crossed && pbuf_ready);
      phone_out_ready = (to_phone && hbuf_ready) || (crossed && rbuf_ready);
   end

   pair_buffer #(.WIDTH(8)) u_radio_buf (.clk(clk), .sys_rst(sys_rst), .ce(ce),
      .in_valid(rbuf_valid), .in_data(rbuf_data), .in_ready(rbuf_ready),
      .out_valid(radio_in_valid), .out_data(radio_in_data), .out_ready(radio_in_ready));
   pair_buffer #(.WIDTH(8)) u_phone_buf (.clk(clk), .sys_rst(sys_rst), .ce(ce),
      .in_valid(pbuf_valid), .in_data(pbuf_data), .in_ready(pbuf_ready),
      .out_valid(phone_in_valid), .out_data(phone_in_data), .out_ready(phone_in_ready));
   pair_buffer #(.WIDTH(8)) u_host_buf (.clk(clk), .sys_rst(sys_rst), .ce(ce),
      .in_valid(hbuf_valid), .in_data(hbuf_data), .in_ready(hbuf_ready),
      .out_valid(host_out_valid), .out_data(host_out_data), .out_ready(host_out_ready));

   // Bytes already in the host buffer may drain, but no new byte enters it.
   chk_route_cross: assert property (@(posedge clk) disable iff (sys_rst)
      crossed |-> (!host_in_ready && !hbuf_valid))
      else $error("host not isolated while modules are joined");

   // ************************************************************
   // Module reset and command-mode entry sequence.
   // ************************************************************
   cmd_state_t cmd_state;
   logic [31:0] hold_cnt;
   logic hold_done;
   logic [1:0] ctrl;
   logic cmd_seen;
   logic cmd_clear;

   assign hold_done = (hold_cnt >= 32'(CMD_HOLD_CYCLES));

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         radio_rst <= 1'b0;
         phone_rst <= 1'b0;
      end else if (ce) begin
         radio_rst <= reset_db || ctrl[path_switch_pkg::CTRL_MOD_RST_BIT];
         phone_rst <= reset_db || ctrl[path_switch_pkg::CTRL_MOD_RST_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cmd_state <= CMD_IDLE;
         hold_cnt <= 32'h0;
         cmd_mode_entry <= 1'b0;
      end else if (ce) begin
         cmd_mode_entry <= 1'b0;
         unique case (cmd_state)
            CMD_IDLE: begin
               if (reset_db && config_db) begin
                  cmd_state <= CMD_BOTH;
               end
            end
            CMD_BOTH: begin
               hold_cnt <= 32'h0;
               if (!config_db) begin
                  cmd_state <= CMD_IDLE;
               end else if (!reset_db) begin
                  cmd_state <= CMD_HOLD;
               end
            end
            CMD_HOLD: begin
               if (reset_db) begin
                  cmd_state <= CMD_BOTH;
               end else if (!config_db) begin
                  cmd_mode_entry <= hold_done;
                  cmd_state <= CMD_IDLE;
               end else if (!hold_done) begin
                  hold_cnt <= hold_cnt + 32'h1;
               end
            end
         endcase
         if (ctrl[path_switch_pkg::CTRL_CMD_REQ_BIT]) begin
            cmd_mode_entry <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cmd_seen <= 1'b0;
      end else if (ce) begin
         if (cmd_mode_entry) begin
            cmd_seen <= 1'b1;
         end else if (cmd_clear) begin
            cmd_seen <= 1'b0;
         end
      end
   end

   chk_module_reset: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && reset_db) |=> (radio_rst && phone_rst))
      else $error("modules not held in reset while button pressed");
   chk_cmd_timing: assert property (@(posedge clk) disable iff (sys_rst)
      (cmd_mode_entry && !$past(ctrl[path_switch_pkg::CTRL_CMD_REQ_BIT]))
      |-> ($past(cmd_state) == CMD_HOLD && $past(hold_done) && !$past(config_db)))
      else $error("command mode entered without the timed release");

   // ************************************************************
   // Fade margin bar graph, activity and carrier indicators.
   // ************************************************************
   logic [7:0] signal_dbm, sens_dbm;
   logic signed [9:0] fade;
   logic [2:0] act_event;
   logic [2:0] act_led;
   logic [31:0] act_cnt [3];

   assign fade = $signed({{2{signal_dbm[7]}}, signal_dbm}) - $signed({{2{sens_dbm[7]}}, sens_dbm});
   assign act_event = {host_out_valid && host_out_ready, host_in_valid && host_in_ready, radio_tx_active};

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         led_signal <= 3'h0;
         led_carrier <= 1'b0;
      end else if (ce) begin
         led_carrier <= phone_line_up && phone_dcd;
         if (fade > path_switch_pkg::FADE_VERY_STRONG) begin
            led_signal <= 3'h7;
         end else if (fade > path_switch_pkg::FADE_STRONG) begin
            led_signal <= 3'h3;
         end else if (fade > path_switch_pkg::FADE_MODERATE) begin
            led_signal <= 3'h1;
         end else begin
            led_signal <= 3'h0;
         end
      end
   end

   // Each event lights or darkens its LED for a visible stretch.
   for (genvar i = 0; i < 3; i++) begin : g_act
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            act_cnt[i] <= 32'h0;
            act_led[i] <= 1'b0;
         end else if (ce) begin
            if (act_event[i]) begin
               act_cnt[i] <= 32'(BLINK_CYCLES);
               act_led[i] <= 1'b1;
            end else if (act_cnt[i] != 32'h0) begin
               act_cnt[i] <= act_cnt[i] - 32'h1;
               act_led[i] <= 1'b1;
            end else begin
               act_led[i] <= 1'b0;
            end
         end
      end
   end

   assign led_power = !act_led[0];
   assign led_serial_in = act_led[1];
   assign led_serial_out = act_led[2];

   chk_bar_three: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && fade > path_switch_pkg::FADE_VERY_STRONG) |=> (led_signal == 3'h7))
      else $error("three bars not shown above top threshold");
   chk_bar_none: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && fade <= path_switch_pkg::FADE_MODERATE) |=> (led_signal == 3'h0))
      else $error("bars shown at weak fade margin");
   chk_fade_source: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && ($signed(signal_dbm) - $signed(sens_dbm)) > 20 && ($signed(signal_dbm) - $signed(sens_dbm)) <= 30)
      |=> (led_signal == 3'h3))
      else $error("two bars not shown for strength minus sensitivity");
   chk_power_blink: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && radio_tx_active) |=> !led_power)
      else $error("power LED not dark during transmission");
   chk_host_traffic: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && host_out_valid && host_out_ready) |=> led_serial_out ##0 1'b1)
      else $error("traffic to host not shown");
   chk_carrier_led: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && !(phone_line_up && phone_dcd)) |=> !led_carrier)
      else $error("carrier LED lit without line and carrier");

   // ************************************************************
   // Avalon-MM register slave, one wait state on every access.
   // ************************************************************
   logic ack;
   logic req;
   logic [31:0] status_word;

   assign req = avs_read || avs_write;
   assign avs_waitrequest = req && !ack;
   assign status_word = {21'h0, led_signal, cmd_seen, panel_db, config_db, reset_db, rts_on, dtr_on, route};
   assign cmd_clear = ack && avs_write && (avs_address == path_switch_pkg::REG_STATUS) && avs_byteenable[0]
      && avs_writedata[path_switch_pkg::STATUS_CMD_SEEN_BIT];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ack <= 1'b0;
         avs_readdata <= 32'h0;
      end else if (ce) begin
         ack <= req && !ack;
         if (avs_read && !ack) begin
            unique case (avs_address)
               path_switch_pkg::REG_CTRL: avs_readdata <= {30'h0, ctrl};
               path_switch_pkg::REG_STATUS: avs_readdata <= status_word;
               path_switch_pkg::REG_SIGNAL: avs_readdata <= {24'h0, signal_dbm};
               path_switch_pkg::REG_SENS: avs_readdata <= {24'h0, sens_dbm};
               default: avs_readdata <= 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl <= path_switch_pkg::CTRL_RESET_VAL;
         signal_dbm <= path_switch_pkg::SIGNAL_RESET_VAL;
         sens_dbm <= path_switch_pkg::SENS_RESET_VAL;
      end else if (ce) begin
         ctrl[path_switch_pkg::CTRL_CMD_REQ_BIT] <= 1'b0;
         if (ack && avs_write && avs_byteenable[0]) begin
            if (avs_address == path_switch_pkg::REG_CTRL) begin
               ctrl <= avs_writedata[1:0];
            end
            if (avs_address == path_switch_pkg::REG_SIGNAL) begin
               signal_dbm <= avs_writedata[7:0];
            end
            if (avs_address == path_switch_pkg::REG_SENS) begin
               sens_dbm <= avs_writedata[7:0];
            end
         end
      end
   end

endmodule // modem_path_switch

// ==== logic/path_switch_pkg.sv ====
/*
 * Constants shared by the modem path switch and its debouncer.
 * Assumes a 100 MHz board clock.
 */
package path_switch_pkg;

   // ************************************************************
   // Clock and times.
   // ************************************************************
   localparam int CLK_HZ = 100_000_000;
   localparam int DEBOUNCE_MS = 10;
   localparam int CMD_HOLD_MS = 1000;
   localparam int BLINK_MS = 50;
   localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;
   localparam int CMD_HOLD_CYCLES = (CLK_HZ / 1000) * CMD_HOLD_MS;
   localparam int BLINK_CYCLES = (CLK_HZ / 1000) * BLINK_MS;

   // ************************************************************
   // Register map (byte addresses) and reset values.
   // ************************************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_SIGNAL = 4'h8;
   localparam logic [3:0] REG_SENS = 4'hc;
   localparam logic [1:0] CTRL_RESET_VAL = 2'h0;
   localparam logic [7:0] SIGNAL_RESET_VAL = 8'h80;
   localparam logic [7:0] SENS_RESET_VAL = 8'h92;
   localparam int CTRL_MOD_RST_BIT = 0;
   localparam int CTRL_CMD_REQ_BIT = 1;
   localparam int STATUS_CMD_SEEN_BIT = 7;

   // ************************************************************
   // Fade margin thresholds in dB.
   // ************************************************************
   localparam logic signed [8:0] FADE_VERY_STRONG = 9'sh01e;
   localparam logic signed [8:0] FADE_STRONG = 9'sh014;
   localparam logic signed [8:0] FADE_MODERATE = 9'sh00a;

   // ************************************************************
   // Data path routes.
   // ************************************************************
   typedef enum logic [1:0] {
      ROUTE_CROSS = 2'h0,
      ROUTE_RADIO = 2'h1,
      ROUTE_PHONE = 2'h2
   } route_t;

   localparam logic [7:0] DATA_RESET_VAL = 8'h00;

endpackage

// ==== logic/input_debounce.sv ====
/*
 * Two-flop synchroniser followed by a stability filter for one contact.
 * Assumes the contact is active high after the panel circuitry.
 */
`timescale 1ns/1ps
module input_debounce #(
   parameter int CYCLES = path_switch_pkg::DEBOUNCE_CYCLES
) (
   // Clocking.
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // Contact.
   input wire logic raw,
   output logic clean
);
   logic sync_a;
   logic sync_b;
   logic [31:0] cnt;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end else if (ce) begin
         sync_a <= raw;
         sync_b <= sync_a;
      end
   end

   // The output follows only once the input has differed for the full time.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt <= 32'h0;
         clean <= 1'b0;
      end else if (ce) begin
         if (sync_b == clean) begin
            cnt <= 32'h0;
         end else if (cnt >= 32'(CYCLES - 1)) begin
            cnt <= 32'h0;
            clean <= sync_b;
         end else begin
            cnt <= cnt + 32'h1;
         end
      end
   end

   chk_debounce_hold: assert property (@(posedge clk) disable iff (sys_rst)
      (clean != $past(clean)) |-> ($past(cnt) >= 32'(CYCLES - 1)))
      else $error("debounced level changed before the filter time");

endmodule // input_debounce

// ==== logic/pair_buffer.sv ====
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes source and sink share the clock.
 */
`timescale 1ns/1ps
module pair_buffer #(
   parameter int WIDTH = 8
) (
   // Clocking.
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // Filling side.
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Draining side.
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   logic [WIDTH-1:0] mem [2];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;
   logic push;
   logic pop;

   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = mem[rd_ptr];
   assign push = ce && in_valid && in_ready;
   assign pop = ce && out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
         mem[0] <= '0;
         mem[1] <= '0;
      end else begin
         if (push) begin
            mem[wr_ptr] <= in_data;
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule // pair_buffer

// ==== testbench/module_pair_model.sv ====
/* Radio and telephone module model: sinks bytes, sources telephone bytes.
   Assumes the switch's byte streams on clk. */
`timescale 1ns/1ps
module module_pair_model (
   // Clocking.
   input wire logic clk,
   // Streams into the modules.
   input wire logic radio_in_valid,
   input wire logic [7:0] radio_in_data,
   output logic radio_in_ready,
   input wire logic phone_in_valid,
   input wire logic [7:0] phone_in_data,
   output logic phone_in_ready,
   // Stream out of the telephone module.
   output logic phone_out_valid,
   output logic [7:0] phone_out_data,
   input wire logic phone_out_ready,
   // Last bytes taken.
   output logic [7:0] radio_got,
   output logic [7:0] phone_got
);
   // The radio stalls every other cycle; the telephone is prompt.
   assign phone_in_ready = 1'b1;
   initial begin
      phone_out_valid = 1'b0;
      phone_out_data = 8'h00;
      radio_in_ready = 1'b0;
      radio_got = 8'h00;
      phone_got = 8'h00;
   end
   always @(posedge clk) begin
      radio_in_ready <= ~radio_in_ready;
      if (radio_in_valid && radio_in_ready) radio_got <= radio_in_data;
      if (phone_in_valid) phone_got <= phone_in_data;
   end
   task automatic send(input logic [7:0] b);
      @(posedge clk);
      phone_out_valid <= 1'b1;
      phone_out_data <= b;
      do @(posedge clk); while (phone_out_ready !== 1'b1);
      phone_out_valid <= 1'b0;
      phone_out_data <= ~b;
   endtask
endmodule // module_pair_model

// ==== testbench/modem_path_switch_tb.sv ====
/* Bench for the modem path switch with short counts.
   Assumes the module pair model on the module side. */
`timescale 1ns/1ps
module modem_path_switch_tb;
   logic clk = 0, sys_rst = 1, dtr = 0, rts = 0, rbtn = 0, cbtn = 0, psw = 0;
   logic rd = 0, wr = 0, hv = 0, tx = 0, lu = 0, dcd = 0, seen = 0, ce = 1, hor = 1;
   logic [3:0] adr = 4'h0;
   logic [31:0] wd = 32'h0, q, rdat;
   logic [7:0] hd = 8'h0, rgot, pgot, rid, pid, pod, hod, hgot;
   logic wreq, hrdy, rv, rr, pv, pr, ov, orr, rrst, prst, cmd, rtsm, lp, lso, lsi, lc, hov, ror;
   logic [2:0] ls;
   logic [7:0] sig_t [5] = '{8'hb1, 8'ha7, 8'h9d, 8'h9c, 8'h9c};
   logic [7:0] sens_t [5] = '{8'h92, 8'h92, 8'h92, 8'h92, 8'h87};
   logic [2:0] bar_t [5] = '{3'h7, 3'h3, 3'h1, 3'h0, 3'h3};
   int err_count = 0, cmp_count = 0, cyc = 0;
   modem_path_switch #(.DEBOUNCE_CYCLES(4), .CMD_HOLD_CYCLES(50), .BLINK_CYCLES(8)) u_dut (
      .clk(clk), .sys_rst(sys_rst), .ce(ce), .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wreq),
      .host_dtr(dtr), .host_rts(rts), .reset_button(rbtn), .config_button(cbtn), .rts_panel_switch(psw),
      .host_in_valid(hv), .host_in_data(hd), .host_in_ready(hrdy), .host_out_valid(hov), .host_out_data(hod),
      .host_out_ready(hor), .radio_out_valid(1'b0), .radio_out_data(8'h00), .radio_out_ready(ror),
      .radio_in_valid(rv), .radio_in_data(rid), .radio_in_ready(rr), .radio_tx_active(tx),
      .radio_rst(rrst), .cmd_mode_entry(cmd), .phone_out_valid(ov), .phone_out_data(pod),
      .phone_out_ready(orr), .phone_in_valid(pv), .phone_in_data(pid), .phone_in_ready(pr),
      .phone_line_up(lu), .phone_dcd(dcd), .phone_rst(prst), .rts_to_modules(rtsm), .led_power(lp),
      .led_serial_out(lso), .led_serial_in(lsi), .led_signal(ls), .led_carrier(lc));
   module_pair_model u_pm (.clk(clk), .radio_in_valid(rv), .radio_in_data(rid), .radio_in_ready(rr),
      .phone_in_valid(pv), .phone_in_data(pid), .phone_in_ready(pr), .phone_out_valid(ov),
      .phone_out_data(pod), .phone_out_ready(orr), .radio_got(rgot), .phone_got(pgot));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cmd === 1'b1) seen <= 1'b1;
      if (hov === 1'b1 && hor) hgot <= hod;
      if (cyc == 5000) begin
         err_count++;
         tally_and_finish;
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] m, e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, q & m);
   endtask
   task automatic hsend(input logic [7:0] b);
      @(posedge clk);
      hv <= 1'b1;
      hd <= b;
      do @(posedge clk); while (hrdy !== 1'b1);
      hv <= 1'b0;
      hd <= ~b;
   endtask
   initial begin
      tick(4);
      sys_rst <= 1'b0;
      tick(2);
      chk("power led", 1, lp);
      rdc("unmapped", 4'h2, 32'hffffffff, 0);
      psw <= 1'b1;
      dtr <= 1'b1;
      rts <= 1'b1;
      tick(20);
      rdc("route", 4'h4, 3, 1);
      hsend(8'h3c);
      tick(4);
      chk("radio byte", 8'h3c, rgot);
      chk("green led", 1, lsi);
      chk("rts out", 1, rtsm);
      rts <= 1'b0;
      tick(20);
      rdc("route", 4'h4, 3, 2);
      hsend(8'hc5);
      u_pm.send(8'h69);
      tick(4);
      chk("phone byte", 8'hc5, pgot);
      chk("yellow led", 1, lso);
      chk("host byte", 8'h69, hgot);
      rts <= 1'b1;
      psw <= 1'b0;
      tick(20);
      chk("rts gated", 0, rtsm);
      rdc("route", 4'h4, 3, 2);
      ce <= 1'b0;
      dtr <= 1'b0;
      tick(20);
      chk("frozen", 1, hrdy);
      ce <= 1'b1;
      tick(20);
      rdc("route", 4'h4, 3, 0);
      chk("host ready", 0, hrdy);
      chk("radio ready", 1, ror);
      u_pm.send(8'h96);
      tick(4);
      chk("cross byte", 8'h96, rgot);
      rdc("signal reset", 4'h8, 32'hff, 32'h80);
      rdc("sens reset", 4'hc, 32'hff, 32'h92);
      foreach (sig_t[i]) begin
         bus(1'b1, 4'hc, {24'h0, sens_t[i]});
         bus(1'b1, 4'h8, {24'h0, sig_t[i]});
         tick(4);
         chk("bars", bar_t[i], ls);
      end
      rbtn <= 1'b1;
      tick(1);
      rbtn <= 1'b0;
      tick(20);
      chk("glitch", 0, rrst);
      rbtn <= 1'b1;
      tick(20);
      chk("radio reset", 1, rrst);
      chk("phone reset", 1, prst);
      cbtn <= 1'b1;
      tick(20);
      rbtn <= 1'b0;
      tick(20);
      cbtn <= 1'b0;
      tick(20);
      chk("early entry", 0, seen);
      rbtn <= 1'b1;
      cbtn <= 1'b1;
      tick(20);
      rbtn <= 1'b0;
      tick(70);
      cbtn <= 1'b0;
      tick(20);
      chk("entry", 1, seen);
      rdc("entry seen", 4'h4, 32'h80, 32'h80);
      bus(1'b1, 4'h4, 32'h80);
      rdc("seen cleared", 4'h4, 32'h80, 0);
      bus(1'b1, 4'h0, 32'h2);
      tick(2);
      rdc("soft entry", 4'h4, 32'h80, 32'h80);
      bus(1'b1, 4'h0, 32'h1);
      tick(2);
      chk("soft reset", 1, prst);
      lu <= 1'b1;
      tick(3);
      chk("carrier", 0, lc);
      dcd <= 1'b1;
      tick(3);
      chk("carrier", 1, lc);
      tx <= 1'b1;
      tick(1);
      tx <= 1'b0;
      tick(3);
      chk("power blink", 0, lp);
      tick(12);
      chk("power back", 1, lp);
      tally_and_finish;
   end
endmodule // modem_path_switch_tb
